// File: design/ext_irq_pin_three.sv
// External interrupt pin three: control register, APB slave, edge flag and requests
// Function
// [RQ1] 8-bit control register, fixed bit layout
// [RQ2] Enable bit gates request to CPU
// [RQ3] Priority bit selects level two or one
// [RQ4] Edge select picks rising or falling
// [RQ5] Flag readable, software may only clear
// [RQ6] Reset clears all defined fields
// [RQ7] Output direction drives pin with value
// [RQ8] Selected edge sets flag; request while set
// [RQ9] Flag records edges regardless of enable
// [RQ10] Level bit reports synchronised pin state
//
// Our own choice: the APB slave port.
module ext_irq_pin_three
(
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  pin_in,
	output logic                       pin_out,
	output logic                       pin_oe,
	output ext_irq_pkg::irq_req_s      irq_req
);
	ext_irq_pkg::ctrl_s ctrl_r;
	ext_irq_pkg::ctrl_s ctrl_nxt;
	logic               flag_r;
	logic               flag_nxt;
	logic [31:0]        prdata_r;
	logic [31:0]        prdata_nxt;
	logic               pslverr_r;
	logic               pin_level;
	logic               edge_pulse;

	pin_edge_detect u_edge
	(
		.clock           (clock),
		.nrst            (nrst),
		.pin_in          (pin_in),
		.edge_select_bit (ctrl_r.edge_sel),
		.pin_level       (pin_level),
		.edge_pulse      (edge_pulse)
	);

	// Zero-wait APB: access phase completes in its first cycle
	wire logic hit       = paddr == ext_irq_pkg::ctrl_addr; // [RQ1]
	wire logic setup     = psel & ~penable;
	wire logic wr_access = psel & penable & pwrite & hit;
	wire logic clear_req = wr_access & ~pwdata[ext_irq_pkg::flag_pos]; // [RQ5]

	wire logic [7:0] ctrl_view =
	{
		flag_r,
		pin_level,     // [RQ10]
		1'b0,
		ctrl_r.dir,
		ctrl_r.out_val,
		ctrl_r.edge_sel,
		ctrl_r.prio,
		ctrl_r.en
	}; // [RQ1]

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (wr_access)
		begin
			ctrl_nxt.dir      = pwdata[ext_irq_pkg::dir_pos];
			ctrl_nxt.out_val  = pwdata[ext_irq_pkg::out_pos];
			ctrl_nxt.edge_sel = pwdata[ext_irq_pkg::edge_pos];
			ctrl_nxt.prio     = pwdata[ext_irq_pkg::prio_pos];
			ctrl_nxt.en       = pwdata[ext_irq_pkg::en_pos];
		end
	end

	// Set wins over a simultaneous clear; writing one never sets
	assign flag_nxt = edge_pulse | (flag_r & ~clear_req); // [RQ5] [RQ8] [RQ9]

	// Read data and error are captured in setup and stand until the access phase ends
	wire logic access      = psel & penable;
	wire logic rd_setup    = setup & ~pwrite & hit;
	wire logic pslverr_nxt = setup ? ~hit : (access & pslverr_r);

	assign prdata_nxt = rd_setup ? {24'h000000, ctrl_view} :
		(access ? prdata_r : 32'h0000_0000);

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= ext_irq_pkg::ctrl_s'(ext_irq_pkg::ctrl_reset[4:0]); // [RQ6]
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			flag_r <= 1'b0; // [RQ6]
		end
		else
		begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			prdata_r <= prdata_nxt;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pslverr_r <= 1'b0;
		end
		else
		begin
			pslverr_r <= pslverr_nxt;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

	assign pin_oe  = ctrl_r.dir;     // [RQ7]
	assign pin_out = ctrl_r.out_val; // [RQ7]

	wire logic req = flag_r & ctrl_r.en; // [RQ2] [RQ8]
	assign irq_req.level2_req = req & ctrl_r.prio;  // [RQ3]
	assign irq_req.level1_req = req & ~ctrl_r.prio; // [RQ3]
endmodule // ext_irq_pin_three

// File: design/ext_irq_pkg.sv
// Package: register map, field positions and types of the external interrupt pin block
package ext_irq_pkg;
	localparam logic [31:0] ctrl_addr      = 32'h0000_1019 << 2;
	localparam logic [31:0] ctrl_index     = 32'h0000_1019;
	localparam int          flag_pos       = 7;
	localparam int          level_pos      = 6;
	localparam int          dir_pos        = 4;
	localparam int          out_pos        = 3;
	localparam int          edge_pos       = 2;
	localparam int          prio_pos       = 1;
	localparam int          en_pos         = 0;
	localparam logic [7:0]  ctrl_reset     = 8'h00;
	localparam logic        edge_rise_code = 1'b1;

	typedef struct packed {
		logic dir;
		logic out_val;
		logic edge_sel;
		logic prio;
		logic en;
	} ctrl_s;

	typedef struct packed {
		logic level1_req;
		logic level2_req;
	} irq_req_s;
endpackage

// File: design/pin_edge_detect.sv
// Pin synchroniser with selectable edge detection
module pin_edge_detect
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic pin_in,
	input  wire logic edge_select_bit,
	output logic      pin_level,
	output logic      edge_pulse
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	wire logic rise = sync2_r & ~prev_r;
	wire logic fall = ~sync2_r & prev_r;

	assign pin_level  = sync2_r;
	assign edge_pulse = (edge_select_bit == ext_irq_pkg::edge_rise_code) ? rise : fall; // [RQ4]
endmodule // pin_edge_detect

// File: testbench/ext_irq_props.sv
// Checker of the pin block ports
module ext_irq_props
(
	input wire logic                  clock,
	input wire logic                  nrst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	input wire logic                  pin_out,
	input wire logic                  pin_oe,
	input wire ext_irq_pkg::irq_req_s irq_req
);
	timeunit 1ns;
	timeprecision 1ns;
	wire rd = psel && penable && !pwrite && !pslverr;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_ERR: assert property (pslverr |-> psel && penable) else $error("stray err");
	AST_RSV: assert property (rd |-> prdata[31:8] == 0 && !prdata[5]) else $error("rsv");
	AST_EN: assert property (rd && irq_req != 0 |-> prdata[0]) else $error("en");
	AST_L2: assert property (rd && irq_req.level2_req |-> prdata[1]) else $error("l2");
	AST_L1: assert property (rd && irq_req.level1_req |-> !prdata[1]) else $error("l1");
	AST_ONE: assert property (!(irq_req.level1_req && irq_req.level2_req)) else $error("2");
	AST_PIN: assert property (rd |-> prdata[4:3] == {pin_oe, pin_out}) else $error("pin");
	AST_HOLD: assert property (!$past(psel && penable && pwrite) |-> $stable({pin_oe, pin_out}))
		else $error("oe");
endmodule // ext_irq_props
bind ext_irq_pin_three ext_irq_props u_props (.clock(clock), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
	.pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req));

// File: testbench/pin_src.sv
// Signal source on the pin
module pin_src
(
	input wire logic lvl,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic     pin
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin = pin_oe ? pin_out : lvl;
endmodule // pin_src

// File: testbench/tb_top.sv
// Register bench of the pin block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0;
	logic [31:0]           paddr = 0, pwdata = 0, prdata, r, ra;
	logic                  pready, pslverr, pin_out, pin_oe, pin, e;
	ext_irq_pkg::irq_req_s irq_req;
	int                    failures = 0, cmp_count = 0, cyc = 0;
	ext_irq_pin_three DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin), .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req));
	pin_src src (.lvl(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin(pin));
	initial forever #10 clock = ~clock;
	task print_verdict;
		if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			failures++;
			$display("CHECK FAILED %0t %h %h", $time, g, x);
		end
	endtask
	task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			print_verdict;
		end
	end
	initial
	begin
		ra = ext_irq_pkg::ctrl_addr;
		repeat (5) @(posedge clock);
		nrst <= 1;
		acc(0, ra, 0);
		chk(r, 32'h0);
		chk({31'h0, pready}, 32'h1);
		acc(1, ra, 32'hff);
		repeat (4) @(posedge clock);
		chk({30'h0, pin_oe, pin_out}, 32'h3);
		acc(0, ra, 0);
		chk(r, 32'hdf);
		chk({30'h0, irq_req}, 32'h1);
		acc(1, ra, 32'h7e);
		acc(0, ra, 0);
		chk(r, 32'h5e);
		acc(1, ra, 32'h08);
		repeat (4) @(posedge clock);
		acc(0, ra, 0);
		chk(r, 32'h88);
		chk({30'h0, irq_req}, 32'h0);
		acc(1, ra, 32'h89);
		acc(0, ra, 0);
		chk(r, 32'h89);
		chk({30'h0, irq_req}, 32'h2);
		acc(0, ra + 4, 0);
		chk({r[30:0], e}, 32'h1);
		print_verdict;
	end
endmodule // tb_top
